// *** hw/pmic_ctrl_regs.svh ***
`ifndef PMIC_CTRL_REGS_SVH
`define PMIC_CTRL_REGS_SVH

// ****************************************
// Register addresses on the host bus
// ****************************************
`define ADDR_REG_ONE_VOLT 8'h02
`define ADDR_REG_TWO_VOLT 8'h03
`define ADDR_BUCK_PARAMS 8'h04
`define ADDR_SYS_PARAMS 8'h05
`define ADDR_BUCK_SLEW 8'h06

// ****************************************
// Reset values
// ****************************************
`define RST_REG_VOLT 8'h0c
`define RST_BUCK_PARAMS 8'h0f
`define RST_SYS_PARAMS 8'h2f
`define RST_BUCK_SLEW 8'h11

// ****************************************
// Writable bit masks, reserved bits cleared
// ****************************************
`define MASK_REG_VOLT 8'h3f
`define MASK_BUCK_PARAMS 8'h7f
`define MASK_SYS_PARAMS 8'h7f
`define MASK_BUCK_SLEW 8'h77

// ****************************************
// Field positions
// ****************************************
`define POS_PHASE 6
`define POS_TWO_ULTRA 5
`define POS_ONE_ULTRA 4
`define POS_TWO_DISCH 3
`define POS_ONE_DISCH 2
`define POS_TWO_AUTO 1
`define POS_ONE_AUTO 0
`define POS_HOST_EN 6
`define POS_DELAY_LO 4
`define POS_REG_TWO_EN 3
`define POS_REG_ONE_EN 2
`define POS_BUCK_TWO_EN 1
`define POS_BUCK_ONE_EN 0
`define POS_TWO_SLEW_LO 4
`define POS_ONE_SLEW_LO 0

// Highest legal regulator voltage code
`define VOLT_CODE_MAX 6'h24

`endif

// *** hw/pmic_ctrl_pkg.sv ***
package pmic_ctrl_pkg;

  // Host bus request, one cycle strobes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // Decoded controls towards the analog side
  typedef struct packed {
    logic buck_phase_select;
    logic buck_two_ultrasonic_en;
    logic buck_one_ultrasonic_en;
    logic buck_two_discharge_en;
    logic buck_one_discharge_en;
    logic buck_two_auto_mode;
    logic buck_one_auto_mode;
    logic host_bus_en;
    logic [1:0] buck_power_up_delay;
    logic regulator_two_en;
    logic regulator_one_en;
    logic buck_two_en;
    logic buck_one_en;
    logic [2:0] buck_two_slew_code;
    logic [2:0] buck_one_slew_code;
    logic [5:0] regulator_one_code;
    logic [5:0] regulator_two_code;
  } ctrl_out_t;

  // Delay selection of the buck power-up field
  typedef enum logic [1:0] {
    DELAY_1MS,
    DELAY_50MS,
    DELAY_150MS,
    DELAY_200MS
  } power_up_delay_t;

endpackage : pmic_ctrl_pkg

// *** hw/ctrl_reg8.sv ***
`timescale 1ns/10ps
`include "pmic_ctrl_regs.svh"

// One control register with reset value and writable mask
module ctrl_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  input wire logic core_clk,
  input wire logic rst_sync_b,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);

  logic [7:0] q_r; // Stored value
  logic [7:0] q_nxt; // Next stored value

  // ****************************************
  // Next value: masked bits keep zero
  // ****************************************
  always_comb
  begin
    q_nxt = q_r;
    if (clk_en && wr_en)
    begin
      q_nxt = wdata & WR_MASK;
    end
  end

  // ****************************************
  // Storage, loaded with reset value at start
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      q_r <= RESET_VAL & WR_MASK;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : ctrl_reg8

// *** hw/read_mux.sv ***
`timescale 1ns/10ps
`include "pmic_ctrl_regs.svh"

// Read data selection by address, unmapped reads as zero
module read_mux (
  input wire logic [7:0] addr,
  input wire logic [7:0] reg_one_volt,
  input wire logic [7:0] reg_two_volt,
  input wire logic [7:0] buck_params,
  input wire logic [7:0] sys_params,
  input wire logic [7:0] buck_slew,
  output logic [7:0] rdata,
  output logic hit
);

  // ****************************************
  // Address decode
  // ****************************************
  always_comb
  begin
    hit = 1'b1;
    case (addr)
      `ADDR_REG_ONE_VOLT: rdata = reg_one_volt;
      `ADDR_REG_TWO_VOLT: rdata = reg_two_volt;
      `ADDR_BUCK_PARAMS: rdata = buck_params;
      `ADDR_SYS_PARAMS: rdata = sys_params;
      `ADDR_BUCK_SLEW: rdata = buck_slew;
      default:
      begin
        rdata = 8'h00;
        hit = 1'b0;
      end
    endcase
  end

endmodule : read_mux

// *** hw/pmic_control_register_bank.sv ***
`timescale 1ns/10ps
`include "pmic_ctrl_regs.svh"

module pmic_control_register_bank
  import pmic_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire host_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic addr_err,
  output ctrl_out_t ctrl,
  output logic volt_code_range_err
);

  // ****************************************
  // Reset release through two flip-flops
  // ****************************************
  logic rst_meta_r; // First stage, read only by second
  logic rst_sync_b; // Clean reset for the bank

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  localparam int NREG = 5; // Number of mapped registers
  localparam logic [7:0] ADDRS [NREG] = '{`ADDR_REG_ONE_VOLT, `ADDR_REG_TWO_VOLT,
    `ADDR_BUCK_PARAMS, `ADDR_SYS_PARAMS, `ADDR_BUCK_SLEW};
  localparam logic [7:0] RSTS [NREG] = '{`RST_REG_VOLT, `RST_REG_VOLT,
    `RST_BUCK_PARAMS, `RST_SYS_PARAMS, `RST_BUCK_SLEW};
  localparam logic [7:0] MASKS [NREG] = '{`MASK_REG_VOLT, `MASK_REG_VOLT,
    `MASK_BUCK_PARAMS, `MASK_SYS_PARAMS, `MASK_BUCK_SLEW};

  logic [7:0] regs [NREG]; // Current register contents

  // One register per address; reserved bits held zero by mask
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      ctrl_reg8 #(
        .RESET_VAL(RSTS[gi]),
        .WR_MASK(MASKS[gi])
      ) u_reg (
        .core_clk(core_clk),
        .rst_sync_b(rst_sync_b),
        .clk_en(clk_en),
        .wr_en(req.wr && (req.addr == ADDRS[gi])),
        .wdata(req.wdata),
        .q(regs[gi])
      );
    end
  endgenerate

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] mux_data; // Selected read data
  logic mux_hit; // Address maps to a register
  logic [7:0] rdata_r; // Registered read data
  logic [7:0] rdata_nxt;
  logic rvalid_r; // Read answer strobe
  logic rvalid_nxt;
  logic addr_err_r; // Unmapped access strobe
  logic addr_err_nxt;

  read_mux u_mux (
    .addr(req.addr),
    .reg_one_volt(regs[0]),
    .reg_two_volt(regs[1]),
    .buck_params(regs[2]),
    .sys_params(regs[3]),
    .buck_slew(regs[4]),
    .rdata(mux_data),
    .hit(mux_hit)
  );

  // Answer one cycle after the strobe; reads of holes give zero
  always_comb
  begin
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    addr_err_nxt = 1'b0;
    if (req.rd)
    begin
      rdata_nxt = mux_data;
      rvalid_nxt = 1'b1;
    end
    if ((req.rd || req.wr) && !mux_hit)
    begin
      addr_err_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      addr_err_r <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      addr_err_r <= addr_err_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign addr_err = addr_err_r;

  // ****************************************
  // Field decode toward the converters
  // ****************************************
  always_comb
  begin
    ctrl.regulator_one_code = regs[0][5:0];
    ctrl.regulator_two_code = regs[1][5:0];
    ctrl.buck_phase_select = regs[2][`POS_PHASE];
    ctrl.buck_two_ultrasonic_en = regs[2][`POS_TWO_ULTRA];
    ctrl.buck_one_ultrasonic_en = regs[2][`POS_ONE_ULTRA];
    ctrl.buck_two_discharge_en = regs[2][`POS_TWO_DISCH];
    ctrl.buck_one_discharge_en = regs[2][`POS_ONE_DISCH];
    ctrl.buck_two_auto_mode = regs[2][`POS_TWO_AUTO];
    ctrl.buck_one_auto_mode = regs[2][`POS_ONE_AUTO];
    ctrl.host_bus_en = regs[3][`POS_HOST_EN];
    ctrl.buck_power_up_delay = regs[3][`POS_DELAY_LO +: 2];
    ctrl.regulator_two_en = regs[3][`POS_REG_TWO_EN];
    ctrl.regulator_one_en = regs[3][`POS_REG_ONE_EN];
    ctrl.buck_two_en = regs[3][`POS_BUCK_TWO_EN];
    ctrl.buck_one_en = regs[3][`POS_BUCK_ONE_EN];
    ctrl.buck_two_slew_code = regs[4][`POS_TWO_SLEW_LO +: 3];
    ctrl.buck_one_slew_code = regs[4][`POS_ONE_SLEW_LO +: 3];
  end

  // Codes above the table top are stored but flagged to the analog side
  assign volt_code_range_err = (regs[0][5:0] > `VOLT_CODE_MAX) ||
    (regs[1][5:0] > `VOLT_CODE_MAX);

endmodule : pmic_control_register_bank

// *** tb/reg_bank_sva.sv ***
`timescale 1ns/10ps
`include "pmic_ctrl_regs.svh"
// ****************
// Port checker
// ****************
module reg_bank_sva
  import pmic_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire host_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic addr_err,
  input wire ctrl_out_t ctrl,
  input wire logic volt_code_range_err
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Requests taken at this edge
  wire logic rd_t = req.rd && clk_en;
  wire logic wr_t = req.wr && clk_en;
  // Outside the mapped window
  wire logic bad = req.addr < 8'h02 || req.addr > 8'h06;
  property p_rv; rd_t && !bad |=> rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no read answer");
  // A write to a hole leaves the last read data standing, so only reads must give zero
  property p_bad; (rd_t || wr_t) && bad |=> addr_err; endproperty
  a_bad: assert property (p_bad) else $error("unmapped access");
  property p_bz; rd_t && bad |=> rdata == 8'h00; endproperty
  a_bz: assert property (p_bz) else $error("unmapped read data");
  property p_ok; (rd_t || wr_t) && !bad |=> !addr_err; endproperty
  a_ok: assert property (p_ok) else $error("false address error");
  property p_v1; rd_t && !wr_t && req.addr == `ADDR_REG_ONE_VOLT |=> rdata == {2'b00, ctrl.regulator_one_code};
  endproperty
  a_v1: assert property (p_v1) else $error("volt one read");
  property p_v2; rd_t && !wr_t && req.addr == `ADDR_REG_TWO_VOLT |=> rdata == {2'b00, ctrl.regulator_two_code};
  endproperty
  a_v2: assert property (p_v2) else $error("volt two read");
  property p_bk; wr_t && req.addr == `ADDR_BUCK_PARAMS |=> {ctrl.buck_phase_select, ctrl.buck_two_ultrasonic_en,
    ctrl.buck_one_ultrasonic_en, ctrl.buck_two_discharge_en, ctrl.buck_one_discharge_en, ctrl.buck_two_auto_mode,
    ctrl.buck_one_auto_mode} == $past(req.wdata[6:0]); endproperty
  a_bk: assert property (p_bk) else $error("buck fields");
  property p_sy; wr_t && req.addr == `ADDR_SYS_PARAMS |=> {ctrl.host_bus_en, ctrl.buck_power_up_delay,
    ctrl.regulator_two_en, ctrl.regulator_one_en, ctrl.buck_two_en, ctrl.buck_one_en} == $past(req.wdata[6:0]);
  endproperty
  a_sy: assert property (p_sy) else $error("system fields");
  property p_sl; wr_t && req.addr == `ADDR_BUCK_SLEW |=> {ctrl.buck_two_slew_code, ctrl.buck_one_slew_code} ==
    {$past(req.wdata[6:4]), $past(req.wdata[2:0])}; endproperty
  a_sl: assert property (p_sl) else $error("slew fields");
  // Fields move only on a taken write
  property p_hd; !wr_t |=> $stable(ctrl); endproperty
  a_hd: assert property (p_hd) else $error("field changed");
  property p_rg; volt_code_range_err == (ctrl.regulator_one_code > `VOLT_CODE_MAX ||
    ctrl.regulator_two_code > `VOLT_CODE_MAX); endproperty
  a_rg: assert property (p_rg) else $error("range flag");
endmodule : reg_bank_sva
bind pmic_control_register_bank reg_bank_sva chk (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
  .req(req), .rdata(rdata), .rvalid(rvalid), .addr_err(addr_err), .ctrl(ctrl),
  .volt_code_range_err(volt_code_range_err));

// *** tb/host_model.sv ***
`timescale 1ns/10ps
// ****************
// Host side of the register bus
// ****************
module host_model
  import pmic_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic addr_err,
  output host_req_t req
);
  initial req = '0;
  // One strobe; the answer stands in the cycle after the taking edge
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q, output logic v, e);
    @(negedge core_clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge core_clk);
    // Idle bus shows inverted lines so stale values never match
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = rdata;
    v = rvalid;
    e = addr_err;
  endtask : acc
  // Field change keeps the neighbours by read, merge, write back
  task automatic rmw(input logic [7:0] a, m, d);
    logic [7:0] q;
    logic v, e;
    acc(1'b0, a, 8'h00, q, v, e);
    acc(1'b1, a, (q & ~m) | (d & m), q, v, e);
  endtask : rmw
endmodule : host_model

// *** tb/tb.sv ***
`timescale 1ns/10ps
`include "pmic_ctrl_regs.svh"
`define CHK(n, x, g) begin check_count++; if ((g) !== (x)) begin errors++; $display("MISMATCH %s exp %h got %h", n, x, g); end end
module tb
  import pmic_ctrl_pkg::*;
;
  // ****************
  // Bench
  // ****************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  host_req_t req;
  logic [7:0] rdata, q;
  logic rvalid, addr_err, range_err, v, e;
  ctrl_out_t ctrl;
  int errors = 0;
  int check_count = 0;
  always #2.5 core_clk = ~core_clk;
  pmic_control_register_bank dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req), .rdata(rdata),
    .rvalid(rvalid), .addr_err(addr_err), .ctrl(ctrl), .volt_code_range_err(range_err));
  host_model h (.core_clk(core_clk), .rdata(rdata), .rvalid(rvalid), .addr_err(addr_err), .req(req));
  task print_verdict;
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task wr(input logic [7:0] a, d);
    h.acc(1'b1, a, d, q, v, e);
  endtask : wr
  task chk_rd(input logic [7:0] a, x);
    h.acc(1'b0, a, 8'h00, q, v, e);
    `CHK("rdata", x, q)
    `CHK("rvalid", 1'b1, v)
    `CHK("addr_err", 1'b0, e)
  endtask : chk_rd
  // Reset held ten cycles; first request waits out the synchroniser
  task do_reset;
    @(negedge core_clk);
    rst_b = 1'b0;
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask : do_reset
  task t_reset_vals;
    chk_rd(`ADDR_REG_ONE_VOLT, `RST_REG_VOLT);
    chk_rd(`ADDR_REG_TWO_VOLT, `RST_REG_VOLT);
    chk_rd(`ADDR_BUCK_PARAMS, `RST_BUCK_PARAMS);
    chk_rd(`ADDR_SYS_PARAMS, `RST_SYS_PARAMS);
    chk_rd(`ADDR_BUCK_SLEW, `RST_BUCK_SLEW);
  endtask : t_reset_vals
  // Reserved bits dropped, code ceiling flagged
  task t_volt;
    wr(`ADDR_REG_ONE_VOLT, 8'hff);
    chk_rd(`ADDR_REG_ONE_VOLT, 8'h3f);
    `CHK("range", 1'b1, range_err)
    wr(`ADDR_REG_ONE_VOLT, 8'h24);
    `CHK("range", 1'b0, range_err)
    wr(`ADDR_REG_TWO_VOLT, 8'hc5);
    chk_rd(`ADDR_REG_TWO_VOLT, 8'h05);
    chk_rd(`ADDR_REG_ONE_VOLT, 8'h24);
  endtask : t_volt
  task t_buck;
    wr(`ADDR_BUCK_PARAMS, 8'hff);
    chk_rd(`ADDR_BUCK_PARAMS, 8'h7f);
    `CHK("phase", 1'b1, ctrl.buck_phase_select)
    wr(`ADDR_BUCK_PARAMS, 8'h80);
    chk_rd(`ADDR_BUCK_PARAMS, 8'h00);
    `CHK("mode", 1'b0, ctrl.buck_one_auto_mode)
  endtask : t_buck
  // Every delay code, neighbours kept
  task t_sys;
    for (int k = 0; k < 4; k++)
    begin
      h.rmw(`ADDR_SYS_PARAMS, 8'h30, 8'(k << 4));
      `CHK("delay", 2'(k), ctrl.buck_power_up_delay)
      chk_rd(`ADDR_SYS_PARAMS, 8'h0f | 8'(k << 4));
    end
    wr(`ADDR_SYS_PARAMS, 8'h40);
    `CHK("enables", 5'h10, {ctrl.host_bus_en, ctrl.regulator_two_en, ctrl.regulator_one_en, ctrl.buck_two_en,
      ctrl.buck_one_en})
  endtask : t_sys
  task t_slew;
    wr(`ADDR_BUCK_SLEW, 8'hff);
    chk_rd(`ADDR_BUCK_SLEW, 8'h77);
    wr(`ADDR_BUCK_SLEW, 8'h70);
    `CHK("slew", 6'o70, {ctrl.buck_two_slew_code, ctrl.buck_one_slew_code})
  endtask : t_slew
  // Unmapped place, then a write while frozen
  task t_unmapped;
    wr(8'h07, 8'hff);
    `CHK("addr_err", 1'b1, e)
    h.acc(1'b0, 8'h07, 8'h00, q, v, e);
    `CHK("rdata", 8'h00, q)
    `CHK("addr_err", 1'b1, e)
    clk_en = 1'b0;
    wr(`ADDR_BUCK_SLEW, 8'h00);
    clk_en = 1'b1;
    chk_rd(`ADDR_BUCK_SLEW, 8'h70);
  endtask : t_unmapped
  // A hang is cut short and counted
  initial
  begin
    #100000;
    errors++;
    print_verdict();
  end
  initial
  begin
    do_reset();
    t_reset_vals();
    t_volt();
    t_buck();
    t_sys();
    t_slew();
    t_unmapped();
    do_reset();
    t_reset_vals();
    print_verdict();
  end
endmodule : tb
